/* logic/pdf_pkg.sv */
// Purpose: Shared constants and types for the graphics-port data-phase master.
// Assumes: 1x transfer mode, four bytes moved per clock, one block is four clocks.
// Notes: Grant status codes are the three-bit values seen while the grant is low.
package pdf_pkg;

  localparam int unsigned PDF_AD_W = 32;
  localparam int unsigned PDF_BE_W = 4;
  localparam int unsigned PDF_LEN_W = 8;
  localparam int unsigned PDF_SYNC_W = PDF_AD_W + 2;

  // Clocks per data block and the block phase of the first throttle point.
  localparam logic [1:0] PDF_PH_FIRST = 2'h0;
  localparam logic [1:0] PDF_PH_TP = 2'h2;
  localparam logic [1:0] PDF_PH_LAST = 2'h3;
  localparam logic [2:0] PDF_BLOCK_CLKS = 3'h4;

  // Grant status codes.
  localparam logic [2:0] PDF_ST_RD_LP = 3'h0;
  localparam logic [2:0] PDF_ST_RD_HP = 3'h1;
  localparam logic [2:0] PDF_ST_WR_LP = 3'h2;
  localparam logic [2:0] PDF_ST_WR_HP = 3'h3;

  // Byte enables driven with write data when all lanes carry data.
  localparam logic [3:0] PDF_BE_ALL_N = 4'h0;

  typedef enum logic [2:0] {
    PDF_IDLE = 3'b000,
    PDF_RD_FIRST = 3'b001,
    PDF_XFER = 3'b010,
    PDF_TP_WAIT = 3'b011,
    PDF_GAP = 3'b100
  } pdf_state_e;

  // True when the status code announces a data phase this master takes part in.
  function automatic logic pdf_is_data(input logic [2:0] code);
    return (code == PDF_ST_RD_LP) || (code == PDF_ST_RD_HP) ||
           (code == PDF_ST_WR_LP) || (code == PDF_ST_WR_HP);
  endfunction

  function automatic logic pdf_is_write(input logic [2:0] code);
    return (code == PDF_ST_WR_LP) || (code == PDF_ST_WR_HP);
  endfunction

endpackage

/* logic/pdf_sync.sv */
// Purpose: Two-flop synchroniser bank for level inputs that come from another clock.
// Assumes: Each bit is an independent level; no bus coherency is needed.
// Notes: The first stage is read only by the second stage.
`timescale 1ns/1ps
`default_nettype none
module pdf_sync #(
  parameter int unsigned WIDTH = 1,
  parameter logic [WIDTH-1:0] RST_VAL = '0
) (
  input wire logic clk, // Core clock.
  input wire logic arst_n, // Asynchronous reset, active low.
  input wire logic [WIDTH-1:0] din, // Raw pin levels.
  output logic [WIDTH-1:0] dout // Synchronised levels.
);

  logic [WIDTH-1:0] meta_ff;
  logic [WIDTH-1:0] hold_ff;

  // Both stages reset to the idle pin level so nothing looks active at release.
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      meta_ff <= RST_VAL;
      hold_ff <= RST_VAL;
    end else begin
      meta_ff <= din;
      hold_ff <= meta_ff;
    end
  end

  assign dout = hold_ff;

endmodule
`default_nettype wire

/* logic/pdf_master.sv */
// Purpose: Data-phase engine of a graphics master: takes read data, sends write data.
// Assumes: The user side presents the length of the head transaction when a grant comes.
// Notes: Port pins share the core clock and feed the logic directly; buffer-full is synchronised.
`timescale 1ns/1ps
`default_nettype none
module pdf_master
  import pdf_pkg::*;
#(
  parameter int unsigned LEN_W = PDF_LEN_W
) (
  input wire logic clk, // Core clock, 125 MHz.
  input wire logic arst_n, // Asynchronous reset, active low.
  input wire logic gnt_n, // Grant pin, active low.
  input wire logic [2:0] grant_status_code, // Status code pins, valid with grant.
  input wire logic trdy_n_in, // Target-ready pin level, active low.
  input wire logic irdy_n_in, // Initiator-ready pin level, unused here.
  output logic irdy_n_out, // Initiator-ready drive value, active low.
  output logic irdy_oe, // Initiator-ready output enable, high while driving.
  input wire logic [PDF_AD_W-1:0] ad_in, // Data bus pin levels.
  output logic [PDF_AD_W-1:0] ad_out, // Data bus drive value.
  output logic ad_oe, // Data bus output enable.
  output logic [PDF_BE_W-1:0] cbe_n_out, // Byte enables with write data, active low.
  output logic cbe_oe, // Byte enable output enable.
  output logic read_buffer_full_n, // Low-priority read buffer full, active low.
  input wire logic user_rbf, // User asks to hold off low-priority read grants.
  input wire logic [LEN_W-1:0] head_len, // Clocks of data in the head transaction.
  output logic head_pop, // Pulse: head transaction has started.
  input wire logic user_rd_stall, // User wants a waitstate at read throttle points.
  output logic [PDF_AD_W-1:0] rd_data, // Captured read word.
  output logic rd_valid, // Pulse: rd_data holds a new word.
  output logic rd_hp, // Read data belongs to a high-priority transaction.
  input wire logic [PDF_AD_W-1:0] wr_data, // Next write word from the user.
  input wire logic [PDF_BE_W-1:0] wr_be_n, // Byte enables for wr_data, active low.
  output logic wr_take, // Pulse: wr_data is taken this clock.
  output logic busy // A data transaction is in progress.
);

  logic [PDF_AD_W-1:0] ad_s;
  logic gnt, trdy;
  logic [2:0] st_s;

  // The port pins come from logic on the common clock and are used as sampled.
  // A synchroniser here would push every handshake two clocks past its slot.
  assign gnt = ~gnt_n;
  assign trdy = ~trdy_n_in;
  assign st_s = grant_status_code;
  assign ad_s = ad_in;

  pdf_state_e state_ff, nxt_state;
  logic [1:0] ph_ff, nxt_ph;
  logic [LEN_W-1:0] rem_ff, nxt_rem;
  logic wr_ff, nxt_wr, hp_ff, nxt_hp;
  logic tp_done_ff, nxt_tp_done;
  logic first_ff, nxt_first;
  logic pend_ff, nxt_pend;
  logic [2:0] pend_code_ff, nxt_pend_code;
  logic irdy_hold_ff, rel_ff;
  logic data_now, more, tp_now, irdy_rdy, tp_ok, last_now, start;
  logic [2:0] start_code;

  // More data beyond the current block means a throttle point exists.
  function automatic logic beyond_block(input logic [LEN_W-1:0] rem, input logic [1:0] ph);
    return rem > LEN_W'(PDF_BLOCK_CLKS - {1'b0, ph});
  endfunction

  assign data_now = (state_ff == PDF_XFER) || ((state_ff == PDF_RD_FIRST) && trdy);
  assign more = beyond_block(rem_ff, ph_ff);
  assign tp_now = (data_now && (ph_ff >= PDF_PH_TP) && more && !tp_done_ff) ||
                  (state_ff == PDF_TP_WAIT);
  assign irdy_rdy = ~user_rd_stall | irdy_hold_ff;
  assign tp_ok = tp_now && trdy && (wr_ff || irdy_rdy);
  assign last_now = data_now && (rem_ff == LEN_W'(1));

  // A grant seen while busy is kept until the bus frees; reads never stall at start.
  assign start = (state_ff == PDF_IDLE && gnt && pdf_is_data(st_s)) ||
                 (last_now && pend_ff);
  assign start_code = (state_ff == PDF_IDLE) ? st_s : pend_code_ff;

  // Next-state decision for the data phase.
  always_comb begin
    nxt_state = state_ff;
    nxt_ph = ph_ff;
    nxt_rem = rem_ff;
    nxt_wr = wr_ff;
    nxt_hp = hp_ff;
    nxt_tp_done = tp_done_ff | (tp_ok && data_now);
    nxt_first = 1'b0;
    nxt_pend = pend_ff;
    nxt_pend_code = pend_code_ff;
    if (state_ff != PDF_IDLE && gnt && pdf_is_data(st_s) && !pend_ff) begin
      nxt_pend = 1'b1;
      nxt_pend_code = st_s;
    end
    if (data_now) begin
      nxt_rem = rem_ff - LEN_W'(1);
      nxt_ph = ph_ff + 2'h1;
      nxt_state = PDF_XFER;
      if (last_now) begin
        nxt_state = PDF_IDLE;
      end else if (ph_ff == PDF_PH_LAST) begin
        nxt_tp_done = 1'b0;
        if (tp_done_ff) begin
          nxt_state = PDF_XFER;
        end else if (tp_ok) begin
          nxt_state = PDF_GAP;
        end else begin
          nxt_state = PDF_TP_WAIT;
        end
      end
    end else if (state_ff == PDF_TP_WAIT && tp_ok) begin
      nxt_state = PDF_GAP;
    end else if (state_ff == PDF_GAP) begin
      nxt_state = PDF_XFER;
      nxt_ph = PDF_PH_FIRST;
    end
    if (start) begin
      nxt_wr = pdf_is_write(start_code);
      nxt_hp = (start_code == PDF_ST_RD_HP) || (start_code == PDF_ST_WR_HP);
      nxt_state = nxt_wr ? PDF_XFER : PDF_RD_FIRST;
      nxt_ph = PDF_PH_FIRST;
      nxt_rem = head_len;
      nxt_tp_done = 1'b0;
      nxt_first = nxt_wr;
      if (state_ff != PDF_IDLE) begin
        nxt_pend = 1'b0;
      end
    end
  end

  // Transaction state.
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      state_ff <= PDF_IDLE;
      ph_ff <= PDF_PH_FIRST;
      rem_ff <= '0;
      wr_ff <= 1'b0;
      hp_ff <= 1'b0;
      tp_done_ff <= 1'b0;
      first_ff <= 1'b0;
      pend_ff <= 1'b0;
      pend_code_ff <= PDF_ST_RD_LP;
    end else begin
      state_ff <= nxt_state;
      ph_ff <= nxt_ph;
      rem_ff <= nxt_rem;
      wr_ff <= nxt_wr;
      hp_ff <= nxt_hp;
      tp_done_ff <= nxt_tp_done;
      first_ff <= nxt_first;
      pend_ff <= nxt_pend;
      pend_code_ff <= nxt_pend_code;
    end
  end

  // Once the master shows ready at a point it may not withdraw it, hence the hold.
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      irdy_hold_ff <= 1'b0;
      rel_ff <= 1'b0;
    end else begin
      irdy_hold_ff <= tp_now && !wr_ff && irdy_rdy && !tp_ok;
      rel_ff <= (tp_ok && !wr_ff) || (first_ff && state_ff == PDF_XFER);
    end
  end

  // Initiator-ready is a handshake output: driven at read points, pulsed at write start.
  always_comb begin
    irdy_oe = 1'b0;
    irdy_n_out = 1'b1;
    if (state_ff == PDF_XFER && wr_ff && first_ff) begin
      irdy_oe = 1'b1;
      irdy_n_out = 1'b0;
    end else if (tp_now && !wr_ff) begin
      irdy_oe = 1'b1;
      irdy_n_out = ~irdy_rdy;
    end else if (rel_ff) begin
      irdy_oe = 1'b1;
      irdy_n_out = 1'b1;
    end
  end

  // Write data is loaded one clock ahead so the pins come from flops.
  assign wr_take = (nxt_state == PDF_XFER) && nxt_wr;
  assign head_pop = start;
  assign busy = state_ff != PDF_IDLE;

  // The bus stays driven through a write wait; the last word is simply repeated.
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      ad_out <= '0;
      cbe_n_out <= PDF_BE_ALL_N;
      ad_oe <= 1'b0;
    end else begin
      if (wr_take) begin
        ad_out <= wr_data;
        cbe_n_out <= wr_be_n;
      end
      ad_oe <= nxt_wr && (nxt_state != PDF_IDLE) && (nxt_state != PDF_RD_FIRST);
    end
  end
  assign cbe_oe = ad_oe;

  // Read words are captured whenever target-ready has qualified them.
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      rd_data <= '0;
      rd_valid <= 1'b0;
      rd_hp <= 1'b0;
    end else begin
      rd_valid <= data_now && !wr_ff;
      rd_hp <= hp_ff;
      if (data_now && !wr_ff) begin
        rd_data <= ad_s;
      end
    end
  end

  // Buffer-full may come from the consumer's clock, so it passes two flops.
  // It only gates future low-priority read grants, so the latency costs nothing else.
  pdf_sync #(
    .WIDTH(1),
    .RST_VAL(1'b1)
  ) u_sync (
    .clk(clk),
    .arst_n(arst_n),
    .din(~user_rbf),
    .dout(read_buffer_full_n)
  );

  AST_WR_PULSE: assert property (@(posedge clk) disable iff (!arst_n)
    (irdy_oe && !irdy_n_out && wr_ff) |=> (irdy_oe && irdy_n_out) ##1 !irdy_oe)
    else $error("Write start ready is not one pulse then release.");
  AST_WR_NOWAIT: assert property (@(posedge clk) disable iff (!arst_n)
    (state_ff == PDF_XFER && wr_ff && ph_ff == PDF_PH_FIRST && rem_ff >= LEN_W'(4)) |=>
    (state_ff == PDF_XFER)[*3])
    else $error("Write block stalled inside a block.");
  AST_RD_GAP: assert property (@(posedge clk) disable iff (!arst_n)
    (state_ff == PDF_TP_WAIT && tp_ok) |=> ##1 (state_ff == PDF_XFER && ph_ff == PDF_PH_FIRST))
    else $error("Read block did not resume two clocks after point.");
  AST_TP_DRIVEN: assert property (@(posedge clk) disable iff (!arst_n)
    (tp_now && !wr_ff) |-> irdy_oe)
    else $error("Initiator ready floats at a read throttle point.");
  AST_RELEASE: assert property (@(posedge clk) disable iff (!arst_n)
    ($fell(irdy_oe)) |-> $past(irdy_n_out))
    else $error("Initiator ready floated while asserted.");
  AST_TP_PHASE: assert property (@(posedge clk) disable iff (!arst_n)
    (data_now && ph_ff < PDF_PH_TP) |-> !tp_now)
    else $error("Throttle point before third clock of block.");
  AST_NO_START_STALL: assert property (@(posedge clk) disable iff (!arst_n)
    (state_ff == PDF_RD_FIRST) |-> !irdy_oe)
    else $error("Initiator ready used to hold off read start.");
  AST_HOLD: assert property (@(posedge clk) disable iff (!arst_n)
    (tp_now && !wr_ff && !irdy_n_out && !tp_ok) |=> (!tp_now || !irdy_n_out))
    else $error("Initiator ready withdrawn at a throttle point.");
  AST_SHORT_RD: assert property (@(posedge clk) disable iff (!arst_n)
    (data_now && !wr_ff && rem_ff <= LEN_W'(2) && ph_ff == PDF_PH_TP) |-> !tp_now)
    else $error("Throttle point inside a final short read.");
  COV_RD_WAIT: cover property (@(posedge clk) disable iff (!arst_n)
    state_ff == PDF_TP_WAIT && !wr_ff ##1 state_ff == PDF_GAP);
  COV_WR_TP: cover property (@(posedge clk) disable iff (!arst_n)
    tp_ok && wr_ff && data_now);
  COV_PIPE: cover property (@(posedge clk) disable iff (!arst_n) last_now && pend_ff);

endmodule
`default_nettype wire

/* tb/pdf_target_model.sv */
// Purpose: Behavioural target and arbiter that grants and moves data phases.
// Assumes: Ready wires have pull-ups; read word n carries 32'hc000_0000 plus n.
// Notes: The target stalls only the first throttle point, for twait clocks.
`timescale 1ns/1ps
`default_nettype none
module pdf_target_model
  import pdf_pkg::*;
(
  input wire logic clk, // Core clock.
  input wire logic irdy_n, // Initiator-ready wire.
  input wire logic rbf_n, // Read buffer full wire.
  input wire logic [PDF_AD_W-1:0] ad, // Data bus wire.
  output logic gnt_n, // Grant pin.
  output logic [2:0] grant_status_code, // Status pins.
  output logic trdy_n, // Target-ready wire.
  output logic [PDF_AD_W-1:0] dev_ad // Read data, else a toggling pattern.
);
  logic trdy_en = 1'b0;
  logic trdy_v = 1'b1;
  logic [PDF_AD_W-1:0] wr_q [$];

  // A released ready floats high through its pull-up.
  assign trdy_n = trdy_en ? trdy_v : 1'b1;

  initial begin
    gnt_n = 1'b1;
    grant_status_code = 3'h7;
    dev_ad = 32'h0;
  end

  // Grant is shown for exactly one clock.
  task automatic pulse_grant(input logic [2:0] code);
    @(posedge clk);
    #1 gnt_n = 1'b0;
    grant_status_code = code;
    @(posedge clk);
    #1 gnt_n = 1'b1;
  endtask

  // A driven-low ready is first driven high for a clock, then floated.
  task automatic settle(input bit tp, input bit ready);
    if (tp) begin
      trdy_en = 1'b1;
      trdy_v = !ready;
    end else if (trdy_en && !trdy_v) begin
      trdy_v = 1'b1;
    end else begin
      trdy_en = 1'b0;
    end
  endtask

  // Grants one transaction and moves it block by block.
  task automatic run(input logic [2:0] code, input int len, input int twait, output bit ok);
    int k;
    int w;
    int cdone;
    bit wr;
    bit go;
    bit done;
    wr = code[1];
    k = 0;
    w = 0;
    cdone = 0;
    done = 1'b1;
    wr_q = {};
    while (code == PDF_ST_RD_LP && rbf_n !== 1'b1 && k < 50) begin
      @(posedge clk);
      k++;
    end
    k = 0;
    pulse_grant(code);
    while (w < len && k < 80) begin
      go = (w % 4 != 0) || (w == 0 && !wr) || (w > 0 && done && k > cdone);
      if (go && w % 4 == 2 && w + 2 < len) done = 1'b0;
      if (!done) settle(1'b1, twait <= 0);
      else if (w == 0 && !wr) begin
        trdy_en = 1'b1;
        trdy_v = 1'b0;
      end else settle(1'b0, 1'b0);
      dev_ad = (go && !wr) ? PDF_AD_W'(32'hc000_0000 + w) : ~dev_ad;
      @(posedge clk);
      k++;
      if (wr && w == 0) go = (irdy_n === 1'b0);
      if (go && wr) wr_q.push_back(ad);
      if (go) w++;
      if (!done && trdy_n === 1'b0 && (wr || irdy_n === 1'b0)) begin
        done = 1'b1;
        cdone = k;
      end else if (!done) begin
        twait--;
      end
      #1;
    end
    repeat (2) begin
      settle(1'b0, 1'b0);
      dev_ad = ~dev_ad;
      @(posedge clk);
      #1;
    end
    ok = (w == len);
  endtask
endmodule
`default_nettype wire

/* tb/port_data_flow_throttle_test.sv */
// Purpose: Self-checking bench for the data-phase master against a target model.
// Assumes: Write word n from the user is 32'ha000_0000 plus n.
// Notes: Ready and data wires are resolved here; a released ready floats high, a released bus carries the target's dev_ad.
`timescale 1ns/1ps
`default_nettype none
module port_data_flow_throttle_test
  import pdf_pkg::*;
;
  logic clk = 1'b0;
  logic arst_n = 1'b0;
  logic user_rbf = 1'b0;
  logic user_rd_stall = 1'b0;
  logic [7:0] head_len = 8'h0;
  logic [31:0] wr_idx = 32'h0;
  logic prev_oe = 1'b0;
  logic prev_n = 1'b1;
  logic irdy_n_out, irdy_oe, ad_oe, read_buffer_full_n, head_pop, rd_valid, rd_hp;
  logic wr_take, busy, gnt_n, trdy_n, cbe_oe;
  logic [3:0] cbe_n;
  logic [2:0] code;
  logic [PDF_AD_W-1:0] ad_out, rd_data, dev_ad;
  logic [31:0] rd_q [$];
  int err_count = 0;
  int compares = 0;
  int pops = 0;
  wire irdy_n = irdy_oe ? irdy_n_out : 1'b1;
  wire [PDF_AD_W-1:0] ad = ad_oe ? ad_out : dev_ad;
  wire [PDF_AD_W-1:0] wr_data = 32'ha000_0000 + wr_idx;

  pdf_master uut (
    .clk(clk), .arst_n(arst_n), .gnt_n(gnt_n), .grant_status_code(code), .trdy_n_in(trdy_n),
    .irdy_n_in(irdy_n), .irdy_n_out(irdy_n_out), .irdy_oe(irdy_oe), .ad_in(ad),
    .ad_out(ad_out), .ad_oe(ad_oe), .cbe_n_out(cbe_n), .cbe_oe(cbe_oe),
    .read_buffer_full_n(read_buffer_full_n), .user_rbf(user_rbf), .head_len(head_len),
    .head_pop(head_pop), .user_rd_stall(user_rd_stall), .rd_data(rd_data),
    .rd_valid(rd_valid), .rd_hp(rd_hp), .wr_data(wr_data), .wr_be_n(4'h0),
    .wr_take(wr_take), .busy(busy)
  );
  pdf_target_model dev (
    .clk(clk), .irdy_n(irdy_n), .rbf_n(read_buffer_full_n), .ad(ad), .gnt_n(gnt_n),
    .grant_status_code(code), .trdy_n(trdy_n), .dev_ad(dev_ad)
  );

  initial begin
    forever #4 clk = ~clk;
  end

  task automatic cmp(input string what, input logic [31:0] exp, input logic [31:0] got);
    compares++;
    if (got !== exp) begin
      err_count++;
      $display("unexpected %s: expected %h, seen %h", what, exp, got);
    end
  endtask

  task automatic report_and_stop();
    if (err_count == 0 && compares > 0) begin
      $display("Run complete: PASS");
    end else begin
      $display("Run complete: FAIL");
    end
    $finish;
  endtask

  // Record read words and starts; the next user word follows each take.
  always @(posedge clk) begin
    if (rd_valid === 1'b1) rd_q.push_back(rd_data);
    if (head_pop === 1'b1) pops++;
    if (wr_take === 1'b1) wr_idx <= #1 wr_idx + 32'h1;
    if (ad_oe === 1'b1) cmp("byte enables", 32'h10, {27'h0, cbe_oe, cbe_n});
  end

  // Initiator-ready must be driven high for a clock before it floats.
  always @(posedge clk) begin
    if (prev_oe === 1'b1 && irdy_oe !== 1'b1) begin
      cmp("irdy before float", 32'h1, {31'h0, prev_n});
    end
    prev_oe <= irdy_oe;
    prev_n <= irdy_n_out;
  end

  // Stall is dropped after ten clocks, so a stalled read must still finish.
  task automatic do_read(input logic [2:0] c, input int len, input int twait, input bit st);
    bit ok;
    rd_q = {};
    head_len = 8'(len);
    user_rd_stall = st;
    fork
      dev.run(c, len, twait, ok);
      begin
        repeat (10) @(posedge clk);
        #1 user_rd_stall = 1'b0;
      end
    join
    repeat (4) @(posedge clk);
    #1 cmp("read done", 32'h1, {31'h0, ok});
    cmp("read count", len, rd_q.size());
    foreach (rd_q[i]) cmp("read word", 32'hc000_0000 + i, rd_q[i]);
    cmp("read priority", {31'h0, c[0]}, {31'h0, rd_hp});
    cmp("idle after read", 32'h0, {31'h0, busy});
  endtask

  task automatic do_write(input logic [2:0] c, input int len, input int twait);
    bit ok;
    logic [31:0] base;
    logic [31:0] q [$];
    base = wr_idx;
    head_len = 8'(len);
    dev.run(c, len, twait, ok);
    repeat (4) @(posedge clk);
    #1 q = dev.wr_q;
    cmp("write done", 32'h1, {31'h0, ok});
    cmp("write count", len, q.size());
    foreach (q[i]) cmp("write word", 32'ha000_0000 + base + i, q[i]);
  endtask

  task automatic t_short_reads();
    do_read(PDF_ST_RD_LP, 2, 0, 1'b0);
    do_read(PDF_ST_RD_HP, 4, 0, 1'b1);
  endtask

  task automatic t_long_reads();
    do_read(PDF_ST_RD_HP, 8, 0, 1'b0);
    do_read(PDF_ST_RD_LP, 12, 0, 1'b1);
    do_read(PDF_ST_RD_LP, 8, 2, 1'b0);
  endtask

  task automatic t_writes();
    do_write(PDF_ST_WR_LP, 4, 0);
    do_write(PDF_ST_WR_HP, 12, 2);
    do_write(PDF_ST_WR_HP, 6, 0);
  endtask

  // A grant with a code outside the data set must start nothing.
  task automatic t_reserved_code();
    int p;
    p = pops;
    dev.pulse_grant(3'h4);
    repeat (6) @(posedge clk);
    #1 cmp("starts after reserved code", p, pops);
    cmp("idle after reserved code", 32'h0, {31'h0, busy});
  endtask

  task automatic t_buffer_full();
    user_rbf = 1'b1;
    repeat (2) @(posedge clk);
    #1 cmp("buffer full pin", 32'h0, {31'h0, read_buffer_full_n});
    user_rbf = 1'b0;
    repeat (2) @(posedge clk);
    #1 cmp("buffer free pin", 32'h1, {31'h0, read_buffer_full_n});
  endtask

  initial begin
    repeat (12) @(posedge clk);
    #1 arst_n = 1'b1;
    repeat (3) @(posedge clk);
    #1;
    t_short_reads();
    t_long_reads();
    t_writes();
    t_reserved_code();
    t_buffer_full();
    report_and_stop();
  end

  // Every scenario ends well within a few hundred clocks.
  initial begin
    repeat (5000) @(posedge clk);
    err_count++;
    report_and_stop();
  end
endmodule
`default_nettype wire
